// file: rtl/mdsp_fifo.sv
`timescale 1ns/100ps
module mdsp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Fill side
    mdsp_word_if.snk wr,
    // Drain side
    mdsp_word_if.src rd
);
    import mdsp_pkg::*;
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0] wptr;
        logic [AW:0] rptr;
    } mdsp_fifo_s;
    mdsp_fifo_s fr_reg;
    mdsp_fifo_s fr_next;
    logic full;
    logic empty;

    always_comb begin
        full = (fr_reg.wptr[AW] != fr_reg.rptr[AW]) &&
            (fr_reg.wptr[AW-1:0] == fr_reg.rptr[AW-1:0]);
        empty = (fr_reg.wptr == fr_reg.rptr);
        fr_next = fr_reg;
        if (wr.valid && !full) begin
            fr_next.mem[fr_reg.wptr[AW-1:0]] = wr.data;
            fr_next.wptr = fr_reg.wptr + 1'b1;
        end
        if (rd.ready && !empty) begin
            fr_next.rptr = fr_reg.rptr + 1'b1;
        end
    end

    assign wr.ready = !full;
    assign rd.valid = !empty;
    assign rd.data = fr_reg.mem[fr_reg.rptr[AW-1:0]];

    always_ff @(posedge core_clk) begin
        if (rst) begin
            fr_reg <= '0;
        end else begin
            fr_reg <= fr_next;
        end
    end
endmodule // mdsp_fifo

// file: rtl/mdsp_pkg.sv
package mdsp_pkg;
    localparam int WORD_W = 16;
    localparam int RD_BIT = 15;
    localparam int ADR_HI = 14;
    localparam int ADR_LO = 8;
    localparam logic [15:0] NOOP_WORD = 16'h0000;
    localparam logic [6:0] ADR_CFG = 7'h04;
    localparam logic [6:0] ADR_GPTR = 7'h05;
    localparam logic [6:0] ADR_GDAT = 7'h06;
    localparam logic [6:0] ADR_DIG0 = 7'h20;
    localparam int CFG_BICOLOR = 0;
    localparam int CFG_BLINK_EN = 1;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam int RB_LAG = 2;
    localparam int NUM_DIGITS = 4;
    localparam int NUM_USER = 24;
    localparam int NUM_FIXED = 104;
    localparam int GLYPH_ROWS = 7;
    localparam int GLYPH_COLS = 5;
    localparam int NUM_ROWS = 14;
    localparam int NUM_COLS = 10;
    localparam int RAM_WORDS = NUM_USER * GLYPH_ROWS;
    localparam int FIFO_DEPTH_DEF = 16;
    localparam int CORE_HZ = 50_000_000;
    localparam int SCAN_HZ = 4_000_000;
    localparam int SCAN_DIV = CORE_HZ / SCAN_HZ;
    localparam int BLINK_HALF_MS = 500;
    localparam int BLINK_STEPS_DEF = SCAN_HZ / 1000 * BLINK_HALF_MS;
    typedef enum logic [1:0] {
        SC_IDLE,
        SC_FETCH_LO,
        SC_FETCH_HI,
        SC_SHOW
    } mdsp_scan_e;
endpackage

// file: rtl/mdsp_top.sv
`timescale 1ns/100ps
// Behaviour
// - Shift serial input on each link clock rise
// - Ignore link clock while select high
// - Capture last 16 bits on select rise
// - Echo input at output 15.5 cycles later
// - Update serial output on falling edge
// - Serial output always driven, never released
// - Blink phase on open-drain pin
// - 128 glyphs: 104 fixed, 24 user
// - User glyphs loaded serially into volatile storage
// - Four mono 5x7 digits; bicolor config bit unused
// - High outputs sink rows, high source columns
// - Digit pairs share rows, differ in columns
// - MSB first; read bit, address, data
// - All-zero word is no operation
// - Read loads register into bits 8:1 of the next output frame
module mdsp_top #(
    parameter int BLINK_STEPS = mdsp_pkg::BLINK_STEPS_DEF,
    parameter int FIFO_DEPTH = mdsp_pkg::FIFO_DEPTH_DEF
) (
    // Core clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Serial link
    input wire logic link_clk,
    input wire logic cs_n,
    input wire logic din,
    output logic dout,
    // Multiplex clock
    input wire logic mux_clock_in,
    input wire logic mux_ext_sel,
    // Blink pin, open drain
    output logic blink_o,
    output logic blink_oe_n,
    // LED drivers
    output logic [mdsp_pkg::NUM_ROWS-1:0] cathode_row_outputs,
    output logic [mdsp_pkg::NUM_COLS-1:0] anode_column_outputs,
    // Status
    output logic cmd_drop
);
    import mdsp_pkg::*;
    localparam int DIV_W = $clog2(SCAN_DIV);
    localparam int BLK_W = $clog2(BLINK_STEPS);
    localparam int RAM_AW = $clog2(RAM_WORDS);

    typedef struct packed {
        logic [WORD_W-1:0] sr;
        logic rst_s1;
        logic rst_s2;
        logic tg_s1;
        logic tg_s2;
        logic tg_seen;
    } mdsp_lnk_s;

    typedef struct packed {
        logic cs_s1;
        logic cs_s2;
        logic cs_s3;
        logic mx_s1;
        logic mx_s2;
        logic mx_s3;
        logic ex_s1;
        logic ex_s2;
        logic [WORD_W-1:0] word;
        logic push;
        logic drop;
        logic [7:0] rb;
        logic rb_tgl;
        logic [7:0] cfg;
        logic [7:0] gptr;
        logic [NUM_DIGITS-1:0][7:0] digit;
        logic [RAM_WORDS-1:0][GLYPH_COLS-1:0] ram;
        logic [GLYPH_COLS-1:0] ram_q;
        logic [GLYPH_COLS-1:0] lo_row;
        logic [DIV_W-1:0] div;
        logic [BLK_W-1:0] blk_cnt;
        logic blink_ph;
        mdsp_scan_e state;
        logic [3:0] step;
        logic [NUM_ROWS-1:0] rows;
        logic [NUM_COLS-1:0] cols;
    } mdsp_core_s;

    mdsp_lnk_s lr_reg;
    mdsp_lnk_s lr_next;
    mdsp_core_s cr_reg;
    mdsp_core_s cr_next;
    logic dout_reg;
    logic [WORD_W-1:0] eff;
    logic cs_rise;
    logic exec;
    logic tick;
    logic [6:0] addr;
    logic [7:0] dat;
    logic [2:0] row;
    logic [7:0] dig_lo;
    logic [7:0] dig_hi;
    logic [GLYPH_COLS-1:0] hi_row;

    mdsp_word_if #(.W(WORD_W)) wq ();
    mdsp_word_if #(.W(WORD_W)) rq ();

    mdsp_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .core_clk(core_clk),
        .rst(rst),
        .wr(wq.snk),
        .rd(rq.src)
    );

    // Register value returned by a read
    function automatic logic [7:0] reg_value(input mdsp_core_s c,
                                             input logic [6:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a == ADR_CFG) begin
            v = c.cfg;
        end else if (a == ADR_GPTR) begin
            v = c.gptr;
        end else if (a >= ADR_DIG0 && a < ADR_DIG0 + 7'(NUM_DIGITS)) begin
            v = c.digit[a[1:0]];
        end
        return v;
    endfunction

    // Glyph store index of one row of a user glyph
    function automatic logic [RAM_AW-1:0] glyph_idx(input logic [7:0] code,
                                                    input logic [2:0] r);
        logic [RAM_AW-1:0] i;
        i = '0;
        if (code[6:0] < 7'(NUM_USER)) begin
            i = RAM_AW'(code[4:0] * GLYPH_ROWS + r);
        end
        return i;
    endfunction

    // One glyph row, with inversion by the top code bit
    function automatic logic [GLYPH_COLS-1:0] glyph_row(
        input logic [7:0] code,
        input logic [2:0] r,
        input logic [GLYPH_COLS-1:0] q
    );
        logic [GLYPH_COLS-1:0] p;
        if (code[6:0] < 7'(NUM_USER)) begin
            p = q;
        end else begin
            p = code[4:0] ^ {r, 2'b00};
        end
        return code[7] ? ~p : p;
    endfunction

    // Link side shift register
    always_comb begin
        lr_next = lr_reg;
        eff = lr_reg.sr;
        lr_next.rst_s1 = rst;
        lr_next.rst_s2 = lr_reg.rst_s1;
        if (lr_reg.rst_s2) begin
            lr_next.sr = '0;
            lr_next.tg_s1 = 1'b0;
            lr_next.tg_s2 = 1'b0;
            lr_next.tg_seen = 1'b0;
        end else if (!cs_n) begin
            lr_next.tg_s1 = cr_reg.rb_tgl;
            lr_next.tg_s2 = lr_reg.tg_s1;
            lr_next.tg_seen = lr_reg.tg_s2;
            if (lr_reg.tg_s2 != lr_reg.tg_seen) begin
                eff[RB_LAG+7:RB_LAG] = cr_reg.rb;
            end
            lr_next.sr = {eff[WORD_W-2:0], din};
        end
    end

    always_ff @(posedge link_clk) begin
        lr_reg <= lr_next;
    end

    always_ff @(negedge link_clk) begin
        if (lr_reg.rst_s2) begin
            dout_reg <= 1'b0;
        end else if (!cs_n) begin
            dout_reg <= lr_reg.sr[WORD_W-1];
        end
    end

    assign dout = dout_reg;

    // Core side: capture, execute, scan
    always_comb begin
        cr_next = cr_reg;
        cr_next.cs_s1 = cs_n;
        cr_next.cs_s2 = cr_reg.cs_s1;
        cr_next.cs_s3 = cr_reg.cs_s2;
        cr_next.mx_s1 = mux_clock_in;
        cr_next.mx_s2 = cr_reg.mx_s1;
        cr_next.mx_s3 = cr_reg.mx_s2;
        cr_next.ex_s1 = mux_ext_sel;
        cr_next.ex_s2 = cr_reg.ex_s1;
        cs_rise = cr_reg.cs_s2 && !cr_reg.cs_s3;
        if (wq.ready) begin
            cr_next.push = 1'b0;
        end
        cr_next.drop = 1'b0;
        if (cs_rise) begin
            cr_next.word = lr_reg.sr;
            cr_next.push = 1'b1;
            cr_next.drop = cr_reg.push && !wq.ready;
        end
        cr_next.div = (cr_reg.div == DIV_W'(SCAN_DIV - 1)) ?
            '0 : cr_reg.div + 1'b1;
        tick = cr_reg.ex_s2 ? (cr_reg.mx_s2 && !cr_reg.mx_s3) :
            (cr_reg.div == DIV_W'(SCAN_DIV - 1));
        rq.ready = (cr_reg.state == SC_IDLE) && !tick;
        exec = rq.valid && rq.ready;
        addr = rq.data[ADR_HI:ADR_LO];
        dat = rq.data[7:0];
        if (exec && rq.data != NOOP_WORD) begin
            if (rq.data[RD_BIT]) begin
                cr_next.rb = reg_value(cr_reg, addr);
                cr_next.rb_tgl = !cr_reg.rb_tgl;
            end else if (addr == ADR_CFG) begin
                cr_next.cfg = dat;
            end else if (addr == ADR_GPTR) begin
                cr_next.gptr = dat;
            end else if (addr == ADR_GDAT) begin
                if (cr_reg.gptr < 8'(RAM_WORDS)) begin
                    cr_next.ram[cr_reg.gptr] = dat[GLYPH_COLS-1:0];
                end
                cr_next.gptr = (cr_reg.gptr >= 8'(RAM_WORDS - 1)) ?
                    8'h00 : cr_reg.gptr + 8'h01;
            end else if (addr >= ADR_DIG0 &&
                         addr < ADR_DIG0 + 7'(NUM_DIGITS)) begin
                cr_next.digit[addr[1:0]] = dat;
            end
        end
        row = (cr_reg.step < 4'(GLYPH_ROWS)) ? cr_reg.step[2:0] :
            3'(cr_reg.step - 4'(GLYPH_ROWS));
        dig_lo = cr_reg.digit[{cr_reg.step >= 4'(GLYPH_ROWS), 1'b0}];
        dig_hi = cr_reg.digit[{cr_reg.step >= 4'(GLYPH_ROWS), 1'b1}];
        hi_row = glyph_row(dig_hi, row, cr_reg.ram_q);
        unique case (cr_reg.state)
            SC_IDLE: begin
                if (tick) begin
                    cr_next.step = (cr_reg.step == 4'(NUM_ROWS - 1)) ?
                        4'h0 : cr_reg.step + 4'h1;
                    if (cr_reg.blk_cnt == BLK_W'(BLINK_STEPS - 1)) begin
                        cr_next.blk_cnt = '0;
                        cr_next.blink_ph = !cr_reg.blink_ph;
                    end else begin
                        cr_next.blk_cnt = cr_reg.blk_cnt + 1'b1;
                    end
                    cr_next.state = SC_FETCH_LO;
                end
            end
            SC_FETCH_LO: begin
                cr_next.ram_q = cr_reg.ram[glyph_idx(dig_lo, row)];
                cr_next.state = SC_FETCH_HI;
            end
            SC_FETCH_HI: begin
                cr_next.lo_row = glyph_row(dig_lo, row, cr_reg.ram_q);
                cr_next.ram_q = cr_reg.ram[glyph_idx(dig_hi, row)];
                cr_next.state = SC_SHOW;
            end
            SC_SHOW: begin
                cr_next.rows = NUM_ROWS'(1) << cr_reg.step;
                cr_next.cols = {hi_row, cr_reg.lo_row};
                if (cr_reg.cfg[CFG_BLINK_EN] && cr_reg.blink_ph) begin
                    cr_next.cols = '0;
                end
                cr_next.state = SC_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cr_reg <= '0;
            cr_reg.cfg <= CFG_RESET;
            // Select idles high, so no false rise after reset
            cr_reg.cs_s1 <= 1'b1;
            cr_reg.cs_s2 <= 1'b1;
            cr_reg.cs_s3 <= 1'b1;
        end else begin
            cr_reg <= cr_next;
        end
    end

    assign wq.valid = cr_reg.push;
    assign wq.data = cr_reg.word;
    assign cathode_row_outputs = cr_reg.rows;
    assign anode_column_outputs = cr_reg.cols;
    assign blink_o = 1'b0;
    assign blink_oe_n = cr_reg.blink_ph;
    assign cmd_drop = cr_reg.drop;

    AST_SHIFT: assert property (
        @(posedge link_clk) disable iff (lr_reg.rst_s2)
        !cs_n && lr_reg.tg_s2 == lr_reg.tg_seen
        |=> lr_reg.sr == {$past(lr_reg.sr[WORD_W-2:0]), $past(din)})
        else $error("shift register did not take input bit");

    AST_CS_IDLE: assert property (
        @(posedge link_clk) disable iff (lr_reg.rst_s2)
        cs_n |=> $stable(lr_reg.sr))
        else $error("shift register moved while deselected");

    AST_DOUT: assert property (
        @(negedge link_clk) disable iff (lr_reg.rst_s2)
        !cs_n |=> dout == $past(lr_reg.sr[WORD_W-1]))
        else $error("serial output not top bit at falling edge");

    AST_CAPTURE: assert property (
        @(posedge core_clk) disable iff (rst)
        cr_reg.cs_s2 && !cr_reg.cs_s3
        |=> cr_reg.word == $past(lr_reg.sr) && cr_reg.push)
        else $error("word not captured on select rise");

    AST_NOOP: assert property (
        @(posedge core_clk) disable iff (rst)
        rq.valid && rq.ready && rq.data == NOOP_WORD
        |=> $stable(cr_reg.cfg) && $stable(cr_reg.rb_tgl)
            && $stable(cr_reg.digit) && $stable(cr_reg.gptr))
        else $error("no-op word changed state");

    AST_READ: assert property (
        @(posedge core_clk) disable iff (rst)
        rq.valid && rq.ready && rq.data[RD_BIT]
        |=> cr_reg.rb_tgl != $past(cr_reg.rb_tgl)
            && cr_reg.rb == reg_value($past(cr_reg), $past(addr)))
        else $error("read did not load readback byte");

    AST_WRITE_CFG: assert property (
        @(posedge core_clk) disable iff (rst)
        rq.valid && rq.ready && !rq.data[RD_BIT]
        && rq.data[ADR_HI:ADR_LO] == ADR_CFG
        |=> cr_reg.cfg == $past(rq.data[7:0]))
        else $error("config write lost");

    AST_GLYPH: assert property (
        @(posedge core_clk) disable iff (rst)
        exec && !rq.data[RD_BIT] && addr == ADR_GDAT
        && cr_reg.gptr < 8'(RAM_WORDS)
        |=> cr_reg.ram[$past(cr_reg.gptr)] == $past(dat[GLYPH_COLS-1:0]))
        else $error("user glyph row not stored");

    AST_ROWS: assert property (
        @(posedge core_clk) disable iff (rst)
        cr_reg.state == SC_SHOW |=> $onehot(cathode_row_outputs)
            && cathode_row_outputs[$past(cr_reg.step)])
        else $error("wrong cathode row active");

    AST_SCAN: assert property (
        @(posedge core_clk) disable iff (rst)
        cr_reg.state == SC_IDLE && tick |-> !rq.ready ##4
            cr_reg.state == SC_IDLE)
        else $error("scan step not four cycles");

    COV_CAPTURE: cover property (
        @(posedge core_clk) disable iff (rst) cr_reg.cs_s2 && !cr_reg.cs_s3);
    COV_READ: cover property (
        @(posedge core_clk) disable iff (rst) exec && rq.data[RD_BIT]);
    COV_BLINK: cover property (
        @(posedge core_clk) disable iff (rst) $rose(cr_reg.blink_ph));
    COV_DROP: cover property (
        @(posedge core_clk) disable iff (rst) cr_reg.drop);
endmodule // mdsp_top

// file: rtl/mdsp_word_if.sv
`timescale 1ns/100ps
interface mdsp_word_if #(parameter int W = 16) ();
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// file: test/mdsp_host_model.sv
`timescale 1ns/100ps
module mdsp_host_model (
    // Serial link toward the device
    output logic link_clk,
    output logic cs_n,
    output logic din,
    input wire logic dout
);
    localparam realtime HALF = 62.5;
    logic [31:0] seen;

    initial begin
        link_clk = 1'b0;
        cs_n = 1'b1;
        din = 1'b0;
        seen = '0;
    end

    // clocks with select high, data wandering
    task automatic idle_clocks(input int n);
        for (int i = 0; i < n; i++) begin
            din = ~din;
            #HALF link_clk = 1'b1;
            #HALF link_clk = 1'b0;
        end
    endtask

    // select low, MSB first, data held over each rise
    task automatic frame(input logic [31:0] w, input int n);
        seen = '0;
        #7.3 cs_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            din = w[i];
            #(HALF - 1.0) link_clk = 1'b1;
            #HALF link_clk = 1'b0;
            #1 seen = {seen[30:0], dout};
        end
        #HALF cs_n = 1'b1;
        din = ~din;
    endtask
endmodule // mdsp_host_model

// file: test/mdsp_top_tb.sv
`timescale 1ns/100ps
module mdsp_top_tb;
    import mdsp_pkg::*;
    localparam int BLINK_SIM = 8;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic mux_clock_in = 1'b0;
    logic mux_ext_sel = 1'b0;
    logic link_clk;
    logic cs_n;
    logic din;
    logic dout;
    logic blink_o;
    logic blink_oe_n;
    logic cmd_drop;
    logic [NUM_ROWS-1:0] rows;
    logic [NUM_COLS-1:0] cols;
    int n_errors = 0;
    int checks = 0;

    always #10 core_clk = ~core_clk;

    mdsp_top #(.BLINK_STEPS(BLINK_SIM), .FIFO_DEPTH(16)) mdsp_top_inst (
        .core_clk(core_clk),
        .rst(rst),
        .link_clk(link_clk),
        .cs_n(cs_n),
        .din(din),
        .dout(dout),
        .mux_clock_in(mux_clock_in),
        .mux_ext_sel(mux_ext_sel),
        .blink_o(blink_o),
        .blink_oe_n(blink_oe_n),
        .cathode_row_outputs(rows),
        .anode_column_outputs(cols),
        .cmd_drop(cmd_drop)
    );

    mdsp_host_model mdsp_host_model_inst (
        .link_clk(link_clk),
        .cs_n(cs_n),
        .din(din),
        .dout(dout)
    );

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic test_reset();
        fork
            mdsp_host_model_inst.idle_clocks(3);
            cyc(20);
        join
        rst = 1'b0;
        cyc(1);
        chk("rows after reset", 32'h0, 32'(rows));
        chk("columns after reset", 32'h0, 32'(cols));
        chk("blink enable after reset", 32'h0, 32'(blink_oe_n));
        chk("drop after reset", 32'h0, 32'(cmd_drop));
        // Link side reset sync needs link edges after release
        mdsp_host_model_inst.idle_clocks(3);
        cyc(5);
    endtask

    task automatic test_echo();
        logic held;
        mdsp_host_model_inst.frame(32'h0155, 16);
        held = dout;
        mdsp_host_model_inst.idle_clocks(8);
        chk("dout while deselected", 32'(held), 32'(dout));
        mdsp_host_model_inst.frame(32'(NOOP_WORD), 16);
        chk("echo stream", 32'h02AA, mdsp_host_model_inst.seen);
        cyc(100);
    endtask

    task automatic test_readback();
        logic [15:0] rd [5] = '{16'h8400, 16'hA000, 16'h9000, 16'h8600,
                                16'h0000};
        logic [7:0] ex [4] = '{8'h02, 8'h41, 8'h00, 8'h00};
        mdsp_host_model_inst.frame(32'h000F0402, 20);
        cyc(100);
        mdsp_host_model_inst.frame(32'h2041, 16);
        cyc(100);
        for (int i = 0; i < 5; i++) begin
            mdsp_host_model_inst.frame(32'(rd[i]), 16);
            cyc(100);
            if (i > 0) begin
                chk("readback byte", 32'(ex[i-1]),
                    32'(mdsp_host_model_inst.seen[8:1]));
            end
        end
    endtask

    task automatic test_scan();
        logic [NUM_ROWS-1:0] r;
        mux_ext_sel = 1'b1;
        cyc(30);
        r = rows;
        chk("one row sinking", 32'h1,
            32'((r != '0) && ((r & (r - 1'b1)) == '0)));
        cyc(60);
        chk("rows held without tick", 32'(r), 32'(rows));
        mux_clock_in = 1'b1;
        cyc(6);
        mux_clock_in = 1'b0;
        cyc(10);
        chk("next row", 32'({r[NUM_ROWS-2:0], r[NUM_ROWS-1]}),
            32'(rows));
        mux_ext_sel = 1'b0;
        cyc(20);
    endtask

    task automatic wait_blink(output int t);
        logic ph;
        ph = blink_oe_n;
        t = 0;
        while (blink_oe_n === ph && t < 400) begin
            cyc(1);
            t++;
        end
        if (t == 400) begin
            n_errors++;
            $display("[FAIL] blink wait expected change seen none");
            stop_test();
        end
    endtask

    task automatic test_blink();
        int t;
        wait_blink(t);
        wait_blink(t);
        chk("blink half period", 32'(SCAN_DIV * BLINK_SIM), 32'(t));
        chk("blink data level", 32'h0, 32'(blink_o));
    endtask

    task automatic test_glyph();
        int n;
        logic [15:0] cmd [5] = '{16'h0400, 16'h0500, 16'h0615, 16'h2000,
                                 16'h2180};
        foreach (cmd[i]) begin
            mdsp_host_model_inst.frame(32'(cmd[i]), 16);
            cyc(20);
        end
        mux_ext_sel = 1'b1;
        cyc(30);
        n = 0;
        while (rows !== 14'h0001 && n < 20) begin
            mux_clock_in = 1'b1;
            cyc(6);
            mux_clock_in = 1'b0;
            cyc(10);
            n++;
        end
        if (n == 20) begin
            n_errors++;
            $display("[FAIL] glyph row expected 0001 seen %h", rows);
            stop_test();
        end
        chk("glyph row zero", 32'h1, 32'(rows));
        chk("pair columns", 32'h155, 32'(cols));
        mux_ext_sel = 1'b0;
        cyc(20);
    endtask

    initial begin
        test_reset();
        $display("done: reset");
        test_echo();
        $display("done: echo");
        test_readback();
        $display("done: readback");
        test_scan();
        $display("done: scan");
        test_blink();
        $display("done: blink");
        test_glyph();
        $display("done: glyph");
        stop_test();
    end
endmodule // mdsp_top_tb
